// ### power_down_mode_control.sv
// Contract
// - Standby pin low forces hardware standby from any mode.
// - Hardware standby holds everything reset, stopped, ports floating.
// - Standby rising with reset low enters reset and restarts oscillation.
// - Reset release goes through reset handling then program execution.
// - Stop bit 1 halts the unit at bus cycle end; CPU runs.
// - Stop bit 0 releases the unit at bus cycle end.
// - Stopped units keep internal state, except serial and converter.
// - After reset all units except transfer controller start stopped.
// - Register access to a stopped unit is blocked.
// - Clock stop bit 1 holds clock pin high outside hardware standby.
// - Direction 1, stop 0: clock driven, high in soft standby, float in hw.
// - Direction 0 makes the clock pin a floating input always.
// - Edge select 0 falling, 1 rising; selected edge wakes soft standby.
// - Soft standby holds every I/O port at its present state.
// - Sleep with soft standby select 1 stops CPU, units, oscillator; here only CPU and oscillator stop, unitStop keeps its value.
// - Soft standby wake waits 8192 to 262144 states before clocks.
module power_down_mode_control #(
	parameter int NUM_UNITS = pdmc_pkg::NUM_UNITS
) (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         hwStandbyPinN,
	input  wire logic                         chipResetInN,
	input  wire logic                         nmiPin,
	input  wire logic                         sleepReq,
	input  wire logic                         busCycleEnd,
	input  wire logic                         xferActive,
	input  wire logic [NUM_UNITS-1:0]         unitAccessReq,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [pdmc_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [pdmc_pkg::DATA_W-1:0]  pwdata,
	input  wire logic [3:0]                   pstrb,
	output logic                              pready,
	output logic [pdmc_pkg::DATA_W-1:0]       prdata,
	output logic                              pslverr,
	output logic [NUM_UNITS-1:0]              unitStop,
	output logic [NUM_UNITS-1:0]              unitAccessOk,
	output logic                              chipResetOut,
	output logic                              oscEnable,
	output logic                              cpuRun,
	output logic                              portsFloat,
	output logic                              portsHold,
	output logic                              ramEnable,
	output logic                              nmiWake,
	output logic                              clkOut,
	output logic                              clkOutEn
);
	import pdmc_pkg::*;

	////////////////////////////////////////////////////////////////
	logic [2:0]             sbySync;
	logic [2:0]             rstPinSync;
	logic [2:0]             nmiSync;
	logic                   sbyN;
	logic                   rstPinN;
	logic                   nmiLvl;
	pdmc_mode_e             mode;
	logic [7:0]             sysCtrl;
	logic [7:0]             sbyCtrl;
	logic [7:0]             clkCtrl;
	logic [NUM_UNITS-1:0]   stopReq;
	logic [SETTLE_W-1:0]    settleCnt;
	logic                   clkToggle;
	logic                   hwReset;

	// Forced standby acts directly, not through the synchroniser
	assign hwReset = rst | ~hwStandbyPinN;

	////////////////////////////////////////////////////////////////
	// Change counts once second and third stages agree
	// Only hwReset sees a raw pin; the mode machine reads settled levels
	always_ff @(posedge clk) begin
		sbySync    <= {sbySync[1:0], hwStandbyPinN};
		rstPinSync <= {rstPinSync[1:0], chipResetInN};
		nmiSync    <= {nmiSync[1:0], nmiPin};
		if (sbySync[1] == sbySync[2]) begin
			sbyN <= sbySync[2];
		end
		if (rstPinSync[1] == rstPinSync[2]) begin
			rstPinN <= rstPinSync[2];
		end
		if (nmiSync[1] == nmiSync[2]) begin
			nmiLvl <= nmiSync[2];
		end
	end

	function automatic logic [SETTLE_W-1:0] settle_len(input logic [2:0] sel);
		logic [2:0] s;
		s = (sel > SETTLE_SEL_MAX) ? SETTLE_SEL_MAX : sel;
		return SETTLE_W'(1) << (SETTLE_BASE_LOG + int'(s));
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
		return a == ADDR_W'(ofs);
	endfunction

	////////////////////////////////////////////////////////////////
	// NMI edge per select bit
	logic nmiPrev;
	logic nmiEdge;
	assign nmiEdge = sysCtrl[SYS_EDGE_BIT] ? (nmiLvl & ~nmiPrev) : (~nmiLvl & nmiPrev);
	always_ff @(posedge clk) begin
		nmiPrev <= nmiLvl;
		if (hwReset) begin
			nmiWake <= 1'b0;
		end else begin
			nmiWake <= nmiEdge;
		end
	end

	////////////////////////////////////////////////////////////////
	// Mode machine
	always_ff @(posedge clk) begin
		if (hwReset) begin
			mode      <= PDMC_HW_SBY;
			settleCnt <= '0;
			if (rst) begin
				mode <= PDMC_RESET;
			end
		end else begin
			case (mode)
				PDMC_HW_SBY: begin
					// Wait for the settled pin, so a glitch on the raw pin
					// cannot end standby before the chain has seen it
					if (sbyN) begin
						mode <= PDMC_RESET;
					end
				end
				PDMC_RESET: begin
					if (rstPinN) begin
						mode <= PDMC_RUN;
					end
				end
				PDMC_RUN: begin
					if (!rstPinN) begin
						mode <= PDMC_RESET;
					end else if (sleepReq) begin
						mode <= sbyCtrl[SBY_SOFT_BIT] ? PDMC_SOFT_SBY : PDMC_SLEEP;
					end
				end
				PDMC_SLEEP: begin
					if (!rstPinN) begin
						mode <= PDMC_RESET;
					end else if (nmiEdge) begin
						mode <= PDMC_RUN;
					end
				end
				PDMC_SOFT_SBY: begin
					if (!rstPinN) begin
						mode <= PDMC_RESET;
					end else if (nmiEdge) begin
						// Loaded one short: the zero count still spends a cycle
						mode      <= PDMC_SETTLE;
						settleCnt <= settle_len(sbyCtrl[SETTLE_LSB +: SETTLE_SEL_W]) - 1'b1;
					end
				end
				PDMC_SETTLE: begin
					if (!rstPinN) begin
						mode <= PDMC_RESET;
					end else if (settleCnt == '0) begin
						mode <= PDMC_RUN;
					end else begin
						settleCnt <= settleCnt - 1'b1;
					end
				end
				default: begin
					mode <= PDMC_RESET;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Status outputs per mode
	always_ff @(posedge clk) begin
		if (hwReset) begin
			chipResetOut <= 1'b1;
			oscEnable    <= ~rst ? 1'b0 : 1'b1;
			cpuRun       <= 1'b0;
			portsFloat   <= ~rst;
			portsHold    <= 1'b0;
		end else begin
			chipResetOut <= (mode == PDMC_RESET) | (mode == PDMC_HW_SBY);
			// Oscillator stays off until hardware standby is really left
			oscEnable    <= (mode != PDMC_SOFT_SBY) && (mode != PDMC_HW_SBY);
			cpuRun       <= (mode == PDMC_RUN);
			portsFloat   <= (mode == PDMC_HW_SBY);
			portsHold    <= (mode == PDMC_SOFT_SBY) | (mode == PDMC_SETTLE);
		end
	end

	////////////////////////////////////////////////////////////////
	// APB slave; zero wait state answer
	logic apbAcc;
	logic apbWr;
	assign apbAcc = psel & penable;
	assign apbWr  = apbAcc & pwrite & pstrb[0];

	always_ff @(posedge clk) begin
		if (hwReset) begin
			sysCtrl <= SYS_RESET;
			sbyCtrl <= SBY_RESET;
			clkCtrl <= CLK_RESET;
			stopReq <= NUM_UNITS'(UNIT_STOP_RESET);
		end else if (apbWr) begin
			if (hit(paddr, OFS_SYS_CTRL)) begin
				sysCtrl <= pwdata[7:0];
			end else if (hit(paddr, OFS_STANDBY)) begin
				sbyCtrl <= pwdata[7:0];
			end else if (hit(paddr, OFS_CLK_CTRL)) begin
				clkCtrl <= pwdata[7:0];
			end else if (hit(paddr, OFS_UNIT_STOP)) begin
				stopReq <= pwdata[NUM_UNITS-1:0];
				// Transfer controller stop refused while busy
				if (xferActive && pwdata[XFER_UNIT]) begin
					stopReq[XFER_UNIT] <= stopReq[XFER_UNIT];
				end
			end
		end
	end

	// Read data formed in setup, so pready and prdata leave flops together
	always_ff @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (psel && !penable) begin
				if (hit(paddr, OFS_SYS_CTRL)) begin
					prdata <= DATA_W'(sysCtrl);
				end else if (hit(paddr, OFS_STANDBY)) begin
					prdata <= DATA_W'(sbyCtrl);
				end else if (hit(paddr, OFS_CLK_CTRL)) begin
					prdata <= DATA_W'(clkCtrl);
				end else if (hit(paddr, OFS_UNIT_STOP)) begin
					prdata <= DATA_W'(stopReq);
				end else if (hit(paddr, OFS_STATUS)) begin
					prdata <= DATA_W'({unitStop, 5'(mode)});
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Unit stop applied only at bus cycle end; units keep their own state
	// Access gating lags a new stop by one cycle at most
	always_ff @(posedge clk) begin
		if (hwReset) begin
			unitStop     <= NUM_UNITS'(UNIT_STOP_RESET);
			unitAccessOk <= '0;
			ramEnable    <= SYS_RESET[SYS_RAM_EN_BIT];
		end else begin
			if (busCycleEnd) begin
				unitStop <= stopReq;
			end
			unitAccessOk <= unitAccessReq & ~unitStop;
			ramEnable    <= sysCtrl[SYS_RAM_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// Clock output pin; half rate so it stays a flip-flop
	// Stop waits for a bus end, so the pin never shows a runt pulse
	always_ff @(posedge clk) begin
		if (hwReset) begin
			clkToggle <= 1'b1;
			clkOut    <= 1'b1;
			clkOutEn  <= 1'b0;
		end else begin
			clkToggle <= ~clkToggle;
			clkOutEn  <= clkCtrl[CLK_DIR_BIT];
			if (clkCtrl[CLK_STOP_BIT] && busCycleEnd) begin
				clkOut <= 1'b1;
			end else if (mode == PDMC_SOFT_SBY || mode == PDMC_SETTLE) begin
				clkOut <= 1'b1;
			end else if (!clkCtrl[CLK_STOP_BIT]) begin
				clkOut <= clkToggle;
			end
		end
	end
endmodule

// ### pdmc_pkg.sv
package pdmc_pkg;
	localparam int         DATA_W          = 32;
	localparam int         ADDR_W          = 12;
	localparam int         NUM_UNITS       = 8;
	// Unit index of the data transfer controller
	localparam int         XFER_UNIT       = 0;
	localparam int         CLK_MHZ         = 250;

	// Register offsets (byte addresses)
	localparam logic [11:0] OFS_SYS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_STANDBY     = 12'h004;
	localparam logic [11:0] OFS_CLK_CTRL    = 12'h008;
	localparam logic [11:0] OFS_UNIT_STOP   = 12'h00c;
	localparam logic [11:0] OFS_STATUS      = 12'h010;
	localparam logic [11:0] OFS_SLEEP       = 12'h014;

	// Field positions
	localparam int         SYS_RAM_EN_BIT  = 0;
	localparam int         SYS_EDGE_BIT    = 1;
	localparam int         SBY_SOFT_BIT    = 7;
	localparam int         SETTLE_LSB      = 0;
	localparam int         SETTLE_SEL_W    = 3;
	localparam int         CLK_STOP_BIT    = 0;
	localparam int         CLK_DIR_BIT     = 1;

	// Reset values
	localparam logic [7:0] SYS_RESET       = 8'h01;
	localparam logic [7:0] SBY_RESET       = 8'h00;
	localparam logic [7:0] CLK_RESET       = 8'h00;
	localparam logic [7:0] UNIT_STOP_RESET = 8'hfe;

	// Settle count base: 8192 states, doubling per select step, top at 262144
	localparam int         SETTLE_BASE_LOG = 13;
	localparam logic [2:0] SETTLE_SEL_MAX  = 3'h5;
	localparam int         SETTLE_W        = 19;

	// Recovery window after hardware standby exit on reset pin, 8 ms settle
	localparam int         OSC_SETTLE_US   = 8000;
	localparam int         OSC_SETTLE_CYC  = OSC_SETTLE_US * CLK_MHZ;

	typedef enum logic [2:0] {
		PDMC_RESET,
		PDMC_RUN,
		PDMC_SLEEP,
		PDMC_SOFT_SBY,
		PDMC_SETTLE,
		PDMC_HW_SBY
	} pdmc_mode_e;
endpackage

// ### pdmc_properties.sv
module pdmc_properties #(
	parameter int NUM_UNITS = 8
) (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic                 hwStandbyPinN,
	input wire logic                 chipResetInN,
	input wire logic                 busCycleEnd,
	input wire logic [NUM_UNITS-1:0] unitAccessReq,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pready,
	input wire logic [NUM_UNITS-1:0] unitStop,
	input wire logic [NUM_UNITS-1:0] unitAccessOk,
	input wire logic                 chipResetOut,
	input wire logic                 oscEnable,
	input wire logic                 cpuRun,
	input wire logic                 portsFloat,
	input wire logic                 portsHold,
	input wire logic                 nmiWake,
	input wire logic                 clkOutEn
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_ready_zero: assert property (psel && !penable |=> pready)
		else $error("pready missing in access phase");
	chk_hw_enter: assert property (!hwStandbyPinN ##1 !hwStandbyPinN |=> portsFloat && chipResetOut)
		else $error("hw standby not entered");
	chk_hw_quiet: assert property (portsFloat |-> !oscEnable && !cpuRun && !clkOutEn && !portsHold)
		else $error("activity in hw standby");
	chk_soft_cpu: assert property (portsHold |-> !cpuRun && !portsFloat)
		else $error("cpu runs in soft standby");
	// Pin may force reset mid-cycle, so a falling pin excuses the change
	chk_stop_edge: assert property (!busCycleEnd && cpuRun && hwStandbyPinN && chipResetInN
		|=> $stable(unitStop) || chipResetOut || !hwStandbyPinN)
		else $error("unitStop changed off bus cycle end");
	chk_access_blk: assert property (1 |=> (unitAccessOk & ($past(unitStop) | ~$past(unitAccessReq))) == '0)
		else $error("access to stopped unit");
	chk_wake_pulse: assert property (nmiWake |=> !nmiWake)
		else $error("nmiWake longer than one cycle");
	chk_hw_exit: assert property ($rose(hwStandbyPinN) && !chipResetInN |-> ##[1:10] chipResetOut && oscEnable && !portsFloat)
		else $error("no reset state after hw standby");
	chk_reset_exit: assert property ($rose(chipResetInN) && hwStandbyPinN |-> ##[1:12] !chipResetOut)
		else $error("reset not left");
	cov_wake: cover property (nmiWake);
	cov_soft: cover property (portsHold ##1 !portsHold);
	cov_hw: cover property (portsFloat);
endmodule
bind power_down_mode_control pdmc_properties #(.NUM_UNITS(NUM_UNITS)) chk (.*);

// ### pdmc_board.sv
module pdmc_board #(
	parameter int OSC_CYC = 2000
) (
	input wire logic clk,
	output logic     hwStandbyPinN,
	output logic     chipResetInN,
	output logic     nmiPin
);
	timeunit 1ns;
	timeprecision 1ps;
	// No boot mode pins at this block, nothing to hold
	initial begin
		hwStandbyPinN = 1'b1;
		chipResetInN = 1'b1;
		nmiPin = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	task nmi(input logic v);
		@(posedge clk) nmiPin <= v;
	endtask
	task hw_enter(input logic keepRam);
		if (keepRam) begin
			@(posedge clk) chipResetInN <= 1'b0;
			repeat (10) @(posedge clk);
		end
		@(posedge clk) hwStandbyPinN <= 1'b0;
	endtask
	// Settle hold shortened; a real crystal needs far longer
	task hw_leave();
		@(posedge clk) chipResetInN <= 1'b0;
		repeat (25) @(posedge clk);
		hwStandbyPinN <= 1'b1;
		repeat (OSC_CYC) @(posedge clk);
		chipResetInN <= 1'b1;
	endtask
endmodule

// ### power_down_mode_control_tb.sv
module power_down_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pdmc_pkg::*;
	logic        clk, rst, sleepReq, busCycleEnd, xferActive, psel, penable, pwrite, a;
	logic        pready, pslverr, chipResetOut, oscEnable, cpuRun, portsFloat, portsHold;
	logic        ramEnable, nmiWake, clkOut, clkOutEn, hwStandbyPinN, chipResetInN, nmiPin;
	logic [3:0]  pstrb;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic [7:0]  unitAccessReq, unitStop, unitAccessOk;
	logic [32:0] expQ[$];
	int          error_cnt, checks_done, cycles, n, seed, wakes;
	pdmc_board board (.clk(clk), .hwStandbyPinN(hwStandbyPinN), .chipResetInN(chipResetInN),
		.nmiPin(nmiPin));
	power_down_mode_control dut (.*);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task test_done();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask
	task rd(input logic [11:0] ad, input logic [32:0] e);
		expQ.push_back(e);
		apb(1'b0, ad, 32'h0);
	endtask
	task bus_end();
		@(posedge clk) busCycleEnd <= 1'b1;
		@(posedge clk) busCycleEnd <= 1'b0;
	endtask
	// Read results are judged apart from the driver, oldest note first
	always @(posedge clk) if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
		cmp("pslverr", {31'h0, expQ[0][32]}, {31'h0, pslverr});
		if (!expQ[0][32]) cmp("prdata", expQ[0][31:0], prdata);
		void'(expQ.pop_front());
	end
	always @(posedge clk) begin
		cycles++;
		if (nmiWake === 1'b1) wakes++;
		if (cycles == 30000) begin
			error_cnt++;
			$display("[ERR] run exp done got timeout");
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		{pstrb, sleepReq, busCycleEnd, xferActive, unitAccessReq} = {4'hf, 11'h0};
		seed = 32'h0e88;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_SYS_CTRL, {25'h0, SYS_RESET});
		rd(OFS_STANDBY, {25'h0, SBY_RESET});
		rd(OFS_CLK_CTRL, {25'h0, CLK_RESET});
		rd(OFS_UNIT_STOP, {25'h0, UNIT_STOP_RESET});
		rd(OFS_STATUS, {20'h0, UNIT_STOP_RESET, 5'h1});
		rd(12'h020, {1'b1, 32'h0});
		$display("test reset done");
		v = $random(seed) & 32'hfe;
		apb(1'b1, OFS_UNIT_STOP, v);
		rd(OFS_UNIT_STOP, {1'b0, v});
		@(negedge clk) cmp("unitStop held", 32'hfe, {24'h0, unitStop});
		unitAccessReq <= 8'hff;
		bus_end();
		@(negedge clk) cmp("unitStop", v, {24'h0, unitStop});
		@(negedge clk) cmp("unitAccessOk", ~v & 32'hff, {24'h0, unitAccessOk});
		@(posedge clk) xferActive <= 1'b1;
		apb(1'b1, OFS_UNIT_STOP, v | 32'h1);
		rd(OFS_UNIT_STOP, {1'b0, v});
		xferActive <= 1'b0;
		$display("test unit stop done");
		apb(1'b1, OFS_CLK_CTRL, 32'h2);
		@(negedge clk) a = clkOut;
		@(negedge clk) cmp("clkOut", {31'h0, ~a}, {31'h0, clkOut});
		cmp("clkOutEn", 32'h1, {31'h0, clkOutEn});
		apb(1'b1, OFS_SYS_CTRL, 32'h3);
		apb(1'b1, OFS_STANDBY, 32'h80);
		board.nmi(1'b0);
		repeat (6) @(posedge clk);
		@(posedge clk) sleepReq <= 1'b1;
		@(posedge clk) sleepReq <= 1'b0;
		repeat (4) @(negedge clk);
		cmp("portsHold", 32'h1, {31'h0, portsHold});
		cmp("oscEnable", 32'h0, {31'h0, oscEnable});
		cmp("clkOut soft", 32'h1, {31'h0, clkOut});
		board.nmi(1'b1);
		for (n = 0; n < 9000 && cpuRun !== 1'b1; n++) @(posedge clk);
		cmp("settle", 32'h1, {31'h0, n >= 8192 && n < 8210});
		cmp("nmiWake soft", 32'd1, wakes);
		$display("test soft standby done");
		apb(1'b1, OFS_CLK_CTRL, 32'h3);
		bus_end();
		repeat (3) begin
			@(negedge clk) cmp("clkOut stop", 32'h1, {31'h0, clkOut});
		end
		apb(1'b1, OFS_CLK_CTRL, 32'h0);
		repeat (2) @(negedge clk);
		cmp("clkOutEn off", 32'h0, {31'h0, clkOutEn});
		apb(1'b1, OFS_SYS_CTRL, 32'h0);
		repeat (2) @(negedge clk);
		cmp("ramEnable", 32'h0, {31'h0, ramEnable});
		board.hw_enter(1'b0);
		repeat (3) @(negedge clk);
		cmp("portsFloat", 32'h1, {31'h0, portsFloat});
		cmp("chipResetOut", 32'h1, {31'h0, chipResetOut});
		board.hw_leave();
		for (n = 0; n < 50 && cpuRun !== 1'b1; n++) @(posedge clk);
		@(negedge clk) cmp("cpuRun", 32'h1, {31'h0, cpuRun});
		rd(OFS_SYS_CTRL, {25'h0, SYS_RESET});
		rd(OFS_UNIT_STOP, {25'h0, UNIT_STOP_RESET});
		$display("test hw standby done");
		@(posedge clk) sleepReq <= 1'b1;
		@(posedge clk) sleepReq <= 1'b0;
		rd(OFS_STATUS, {20'h0, UNIT_STOP_RESET, 5'h2});
		@(negedge clk) cmp("sleep cpuRun", 32'h0, {31'h0, cpuRun});
		cmp("sleep oscEnable", 32'h1, {31'h0, oscEnable});
		cmp("sleep portsHold", 32'h0, {31'h0, portsHold});
		board.nmi(1'b0);
		for (n = 0; n < 20 && cpuRun !== 1'b1; n++) @(posedge clk);
		@(negedge clk) cmp("sleep wake", 32'h1, {31'h0, cpuRun});
		cmp("nmiWake falling", 32'd2, wakes);
		$display("test sleep done");
		repeat (2) @(posedge clk);
		test_done();
	end
endmodule
